// ==== src/pdsq_sequencer.sv ====
// Purpose: Attach, gate, protection, supply-select and retry sequencing for a PD source port.
// Assumes: Inputs synchronous to clock_in; analog detection done outside.
// Notes: Long delays are parameters so a simulation may shorten them.
// Summary of operation
// - Arm undervoltage and overcurrent protection 190 ms after gate drive turns on.
// - Send ready indication 260 ms after each requested supply-select change.
// - Keep gate drive off 765 ms after a hard-reset shutdown.
// - Turn gate drive off 30 ms after transmitting a hard reset.
// - Debounce attachment 185 ms before pulling source enable low.
// - Change supply-select outputs 30 ms after accepting a request.
// - Persistent supply fault with sink attached repeats hard resets every 1395 ms.
// - Shorted VBUS with sink attached repeats hard resets every 985 ms.
// - Supply not up 600 ms after source enable low sends hard reset.
// - Silent sink keeps gate on 4.8 s, then hard reset, repeating.
// - Drive attach indicator high within 5 ms of attachment.
// - Fast shutdown input low drops gate drive within 5 us.
// - Fast overvoltage turns gate drive off within 30 us.
// - Large overcurrent starts gate turn-off within 30 us.
// - First thermal trip stops active discharge within 10 us.
// - Slow voltage guards disabled during voltage transitions.
// - Standard pull-up from attachment until gate on, and again after the first message sent after gate on.
// - 3 A pull-up after gate on until the first message is sent or a message is received.
// - 1.5 A pull-up after a message is received.
// - Thermal trip stops active discharge, and in ST_RUN also sends hard reset; bleed stays.
`timescale 1ns/10ps
`include "pdsq_consts.svh"
module pdsq_sequencer
   import pdsq_pkg::*;
#(
   parameter int PROT_ARM_CYC = `PDSQ_PROT_ARM_MS * `PDSQ_CYC_PER_MS,
   parameter int SETTLE_CYC = `PDSQ_SETTLE_MS * `PDSQ_CYC_PER_MS,
   parameter int RECOVER_CYC = `PDSQ_RECOVER_MS * `PDSQ_CYC_PER_MS,
   parameter int HR_GATEOFF_CYC = `PDSQ_HR_GATEOFF_MS * `PDSQ_CYC_PER_MS,
   parameter int DEBOUNCE_CYC = `PDSQ_DEBOUNCE_MS * `PDSQ_CYC_PER_MS,
   parameter int SNK_TRANS_CYC = `PDSQ_SNK_TRANS_MS * `PDSQ_CYC_PER_MS,
   parameter int FAULT_RETRY_CYC = `PDSQ_FAULT_RETRY_MS * `PDSQ_CYC_PER_MS,
   parameter int SHORT_RETRY_CYC = `PDSQ_SHORT_RETRY_MS * `PDSQ_CYC_PER_MS,
   parameter int TURN_ON_CYC = `PDSQ_TURN_ON_MS * `PDSQ_CYC_PER_MS,
   parameter int SILENT_CYC = `PDSQ_SILENT_MS * `PDSQ_CYC_PER_MS
)
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic nrst_in,
   // Port sensing
   input wire logic sink_present_in,
   input wire logic vbus_good_in,
   input wire logic vbus_short_in,
   input wire logic supply_input_in,
   input wire logic fast_shutdown_in,
   input wire logic fast_overvoltage_guard_in,
   input wire logic overcurrent_large_in,
   input wire logic thermal_trip_level_one_in,
   // Protocol side
   input wire logic request_accept_in,
   input wire logic [`PDSQ_SEL_W-1:0] request_select_in,
   input wire logic msg_received_in,
   input wire logic msg_sent_in,
   // Power path outputs
   output logic source_enable_n_out,
   output logic nfet_gate_drive_out,
   output logic protection_armed_out,
   output logic slow_guards_enable_out,
   output logic supply_select_bit1_out,
   output logic supply_select_bit2_out,
   output logic supply_select_bit3_out,
   output logic active_discharge_out,
   output logic bleed_discharge_out,
   output logic attach_indicator_out,
   // Protocol requests
   output logic send_ps_ready_out,
   output logic send_hard_reset_out,
   output pdsq_adv_type cc_advert_out
);
   typedef struct packed {
      pdsq_state_type st;
      logic srcen;
      logic gate;
      logic armed;
      logic [`PDSQ_SEL_W-1:0] sel;
      logic [`PDSQ_SEL_W-1:0] sel_pend;
      logic ps_rdy;
      logic hrst;
      logic discharge;
      logic attach;
      logic sent_after_gate;
      logic heard;
      logic silent_run;
   } pdsq_state_reg_type;

   pdsq_state_reg_type s_q;
   pdsq_state_reg_type s_d;

   logic fault_now;
   logic supply_fault;
   logic main_load;
   logic main_clear;
   logic [`PDSQ_TMR_W-1:0] main_count;
   logic main_exp;
   logic main_run;
   logic arm_load;
   logic arm_exp;
   logic sil_load;
   logic sil_clear;
   logic sil_exp;

   // Hard-reset spacing already covers gate-off, recovery and three state hand-overs.
   localparam int HR_SPENT_CYC = HR_GATEOFF_CYC + RECOVER_CYC + 3;

   // Supply faults keep the gate off; overvoltage and overcurrent are immediate kills.
   assign supply_fault = !fast_shutdown_in || !supply_input_in;
   assign fault_now = supply_fault || fast_overvoltage_guard_in || overcurrent_large_in;

   // The retry interval is chosen by which fault is present; a supply fault beats a short, which beats the turn-on wait.
   function automatic logic [`PDSQ_TMR_W-1:0] retry_cycles(input logic sup, input logic shrt);
      if (sup)
      begin
         return `PDSQ_TMR_W'(FAULT_RETRY_CYC);
      end
      else if (shrt)
      begin
         return `PDSQ_TMR_W'(SHORT_RETRY_CYC);
      end
      else
      begin
         return `PDSQ_TMR_W'(TURN_ON_CYC);
      end
   endfunction

   always_comb
   begin
      s_d = s_q;
      s_d.ps_rdy = 1'b0;
      s_d.hrst = 1'b0;
      main_load = 1'b0;
      main_clear = 1'b0;
      main_count = '0;
      arm_load = 1'b0;
      sil_load = 1'b0;
      sil_clear = 1'b0;
      if (msg_received_in)
      begin
         s_d.heard = 1'b1;
      end
      if (msg_sent_in && s_q.gate)
      begin
         s_d.sent_after_gate = 1'b1;
      end
      if (arm_exp && s_q.gate)
      begin
         s_d.armed = 1'b1;
      end
      if (thermal_trip_level_one_in)
      begin
         s_d.discharge = 1'b0;
      end
      if (!sink_present_in)
      begin
         // Detach aborts every timer and goes back to watching.
         s_d = '0;
         s_d.st = ST_IDLE;
         s_d.srcen = 1'b1;
         s_d.sel = `PDSQ_SEL_RESET;
         s_d.sel_pend = `PDSQ_SEL_RESET;
         s_d.discharge = !thermal_trip_level_one_in;
         main_clear = 1'b1;
         sil_clear = 1'b1;
      end
      else
      begin
         s_d.attach = 1'b1;
         case (s_q.st)
            ST_IDLE:
            begin
               main_load = 1'b1;
               main_count = `PDSQ_TMR_W'(DEBOUNCE_CYC);
               s_d.st = ST_DEBOUNCE;
            end
            ST_DEBOUNCE:
            begin
               if (main_exp)
               begin
                  s_d.srcen = 1'b0;
                  main_load = 1'b1;
                  main_count = `PDSQ_TMR_W'(TURN_ON_CYC);
                  s_d.st = ST_GATE_ON;
               end
            end
            ST_GATE_ON:
            begin
               if (!fault_now && !vbus_short_in && !s_q.gate)
               begin
                  s_d.gate = 1'b1;
                  s_d.discharge = 1'b0;
                  arm_load = 1'b1;
                  sil_load = 1'b1;
                  main_clear = 1'b1;
                  s_d.st = ST_RUN;
               end
               else if (main_exp)
               begin
                  s_d.hrst = 1'b1;
                  main_load = 1'b1;
                  main_count = `PDSQ_TMR_W'(HR_GATEOFF_CYC);
                  s_d.st = ST_HR_WAIT;
               end
            end
            ST_RUN:
            begin
               if (thermal_trip_level_one_in || sil_exp)
               begin
                  s_d.hrst = 1'b1;
                  s_d.discharge = 1'b0;
                  main_load = 1'b1;
                  main_count = `PDSQ_TMR_W'(HR_GATEOFF_CYC);
                  s_d.st = ST_HR_WAIT;
               end
               else if (request_accept_in)
               begin
                  s_d.sel_pend = request_select_in;
                  main_load = 1'b1;
                  main_count = `PDSQ_TMR_W'(SNK_TRANS_CYC);
                  s_d.st = ST_TRANS_WAIT;
               end
               else if (msg_received_in)
               begin
                  sil_load = 1'b1;
               end
            end
            ST_TRANS_WAIT:
            begin
               if (main_exp)
               begin
                  s_d.sel = s_q.sel_pend;
                  main_load = 1'b1;
                  main_count = `PDSQ_TMR_W'(SETTLE_CYC);
                  s_d.st = ST_SETTLE;
               end
            end
            ST_SETTLE:
            begin
               if (main_exp)
               begin
                  s_d.ps_rdy = 1'b1;
                  sil_load = 1'b1;
                  s_d.st = ST_RUN;
               end
            end
            ST_HR_WAIT:
            begin
               if (main_exp)
               begin
                  s_d.gate = 1'b0;
                  s_d.armed = 1'b0;
                  s_d.sel = `PDSQ_SEL_RESET;
                  s_d.discharge = !thermal_trip_level_one_in;
                  s_d.heard = 1'b0;
                  s_d.sent_after_gate = 1'b0;
                  sil_clear = 1'b1;
                  main_load = 1'b1;
                  main_count = `PDSQ_TMR_W'(RECOVER_CYC);
                  s_d.st = ST_RECOVER;
               end
            end
            ST_RECOVER:
            begin
               if (main_exp)
               begin
                  main_load = 1'b1;
                  main_count = retry_cycles(supply_fault, vbus_short_in);
                  if (supply_fault || vbus_short_in)
                  begin
                     main_count = main_count - `PDSQ_TMR_W'(HR_SPENT_CYC);
                  end
                  s_d.st = (supply_fault || vbus_short_in) ? ST_RETRY_WAIT : ST_GATE_ON;
               end
            end
            ST_RETRY_WAIT:
            begin
               if (main_exp)
               begin
                  s_d.hrst = 1'b1;
                  main_load = 1'b1;
                  main_count = `PDSQ_TMR_W'(HR_GATEOFF_CYC);
                  s_d.st = ST_HR_WAIT;
               end
            end
            default:
            begin
               s_d.st = ST_IDLE;
            end
         endcase
         // Immediate gate kill outside the timed sequence; one cycle is far inside the limits.
         if (fault_now && s_q.gate)
         begin
            s_d.gate = 1'b0;
            s_d.armed = 1'b0;
            sil_clear = 1'b1;
            main_load = 1'b1;
            main_count = retry_cycles(supply_fault, vbus_short_in);
            s_d.st = ST_RETRY_WAIT;
         end
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (!nrst_in)
      begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
         s_q.srcen <= 1'b1;
         s_q.discharge <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   pdsq_timer #(.WIDTH(`PDSQ_TMR_W)) u_main_timer (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .load_in(main_load),
      .clear_in(main_clear),
      .count_in(main_count),
      .expired_out(main_exp),
      .running_out(main_run)
   );

   pdsq_timer #(.WIDTH(`PDSQ_TMR_W)) u_arm_timer (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .load_in(arm_load),
      .clear_in(main_clear && !sink_present_in),
      .count_in(`PDSQ_TMR_W'(PROT_ARM_CYC)),
      .expired_out(arm_exp),
      .running_out()
   );

   pdsq_timer #(.WIDTH(`PDSQ_TMR_W)) u_silent_timer (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .load_in(sil_load),
      .clear_in(sil_clear),
      .count_in(`PDSQ_TMR_W'(SILENT_CYC)),
      .expired_out(sil_exp),
      .running_out()
   );

   assign source_enable_n_out = s_q.srcen;
   assign nfet_gate_drive_out = s_q.gate;
   assign protection_armed_out = s_q.armed;
   // Slow guards would trip on a legal voltage step, so they sleep during it.
   assign slow_guards_enable_out = s_q.armed && (s_q.st != ST_TRANS_WAIT)
      && (s_q.st != ST_SETTLE);
   assign supply_select_bit1_out = s_q.sel[0];
   assign supply_select_bit2_out = s_q.sel[1];
   assign supply_select_bit3_out = s_q.sel[2];
   assign active_discharge_out = s_q.discharge;
   assign bleed_discharge_out = !s_q.gate;
   assign attach_indicator_out = s_q.attach;
   assign send_ps_ready_out = s_q.ps_rdy;
   assign send_hard_reset_out = s_q.hrst;
   // Pull-up advertisement ladder.
   assign cc_advert_out = s_q.heard ? ADV_1P5 :
      ((s_q.gate && !s_q.sent_after_gate) ? ADV_3P0 : ADV_STD);

   a_attach_ind: assert property (@(posedge clock_in) disable iff (!nrst_in)
      sink_present_in |=> attach_indicator_out) else $error("attach indicator late");
   a_fault_kill: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (sink_present_in && !fast_shutdown_in && nfet_gate_drive_out) |=> !nfet_gate_drive_out)
      else $error("gate not killed on shutdown");
   a_fast_ov_kill: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (sink_present_in && fast_overvoltage_guard_in) |=> !nfet_gate_drive_out)
      else $error("gate on under overvoltage");
   a_ocp_kill: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (sink_present_in && overcurrent_large_in) |=> !nfet_gate_drive_out)
      else $error("gate on under overcurrent");
   a_thermal_discharge: assert property (@(posedge clock_in) disable iff (!nrst_in)
      thermal_trip_level_one_in |=> !active_discharge_out)
      else $error("discharge not stopped");
   a_detach_abort: assert property (@(posedge clock_in) disable iff (!nrst_in)
      !sink_present_in |=> (source_enable_n_out && !nfet_gate_drive_out && !main_run))
      else $error("detach not aborting");
   a_srcen_debounce: assert property (@(posedge clock_in) disable iff (!nrst_in)
      $fell(source_enable_n_out) |-> $past(s_q.st) == ST_DEBOUNCE)
      else $error("source enable without debounce");
   a_ready_settle: assert property (@(posedge clock_in) disable iff (!nrst_in)
      send_ps_ready_out |-> $past(s_q.st) == ST_SETTLE)
      else $error("ready without settling");
   a_guard_quiet: assert property (@(posedge clock_in) disable iff (!nrst_in)
      $changed({supply_select_bit3_out, supply_select_bit2_out, supply_select_bit1_out})
      |-> !slow_guards_enable_out)
      else $error("slow guards on in transition");
endmodule // pdsq_sequencer

// ==== src/pdsq_consts.svh ====
// Purpose: Timing constants and code widths for the source power path sequencer.
// Assumes: A 50 MHz system clock.
// Notes: Times are kept in their own unit; cycle counts are derived from them.
`ifndef PDSQ_CONSTS_SVH
`define PDSQ_CONSTS_SVH

`define PDSQ_CLK_HZ 50000000
`define PDSQ_CYC_PER_MS (`PDSQ_CLK_HZ / 1000)
`define PDSQ_CYC_PER_US (`PDSQ_CLK_HZ / 1000000)
`define PDSQ_PROT_ARM_MS 190
`define PDSQ_SETTLE_MS 260
`define PDSQ_RECOVER_MS 765
`define PDSQ_HR_GATEOFF_MS 30
`define PDSQ_DEBOUNCE_MS 185
`define PDSQ_SNK_TRANS_MS 30
`define PDSQ_FAULT_RETRY_MS 1395
`define PDSQ_SHORT_RETRY_MS 985
`define PDSQ_TURN_ON_MS 600
`define PDSQ_SILENT_MS 4800
`define PDSQ_ATTACH_IND_MS 5
`define PDSQ_GATE_OFF_US 5
`define PDSQ_FAST_OV_US 30
`define PDSQ_OCP_US 30
`define PDSQ_DISCHARGE_STOP_US 10
`define PDSQ_SEL_W 3
`define PDSQ_SEL_RESET 3'h0
`define PDSQ_TMR_W 28

`endif

// ==== src/pdsq_pkg.sv ====
// Purpose: Types for the source power path sequencer.
// Assumes: Nothing beyond the constants header.
// Notes: Advertisement codes drive the CC pull-up selector.
package pdsq_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_DEBOUNCE = 4'h1,
      ST_GATE_ON = 4'h2,
      ST_RUN = 4'h3,
      ST_TRANS_WAIT = 4'h4,
      ST_SETTLE = 4'h5,
      ST_HR_WAIT = 4'h6,
      ST_RECOVER = 4'h7,
      ST_RETRY_WAIT = 4'h8
   } pdsq_state_type;

   typedef enum logic [1:0] {
      ADV_STD = 2'h0,
      ADV_1P5 = 2'h1,
      ADV_3P0 = 2'h2
   } pdsq_adv_type;
endpackage

// ==== src/pdsq_timer.sv ====
// Purpose: Down counter that signals expiry of a loaded delay.
// Assumes: Load wins over counting; clear stops it.
// Notes: Expiry is a one-cycle pulse when the count steps from one to zero.
`timescale 1ns/10ps
module pdsq_timer #(
   parameter int WIDTH = 28
)
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic nrst_in,
   // Control
   input wire logic load_in,
   input wire logic clear_in,
   input wire logic [WIDTH-1:0] count_in,
   // Status
   output logic expired_out,
   output logic running_out
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic exp;
   } pdsq_tmr_type;
   pdsq_tmr_type s_q;
   pdsq_tmr_type s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.exp = 1'b0;
      if (clear_in)
      begin
         s_d.cnt = '0;
      end
      else if (load_in)
      begin
         s_d.cnt = count_in;
      end
      else if (s_q.cnt != '0)
      begin
         s_d.cnt = s_q.cnt - 1'b1;
         s_d.exp = (s_q.cnt == {{(WIDTH-1){1'b0}}, 1'b1});
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (!nrst_in)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign expired_out = s_q.exp;
   assign running_out = (s_q.cnt != '0);
endmodule // pdsq_timer

// ==== verification/pdsq_sink_model.sv ====
// Purpose: Attached sink on the CC wire, facing the sequencer's protocol side.
// Assumes: The bench commands attachment and requests; the model times the wire side.
// Notes: A new request waits for the ready or hard-reset announcement of the last one.
`timescale 1ns/10ps
`include "pdsq_consts.svh"
module pdsq_sink_model
(
   // Clock
   input wire logic clock_in,
   // Bench commands
   input wire logic attach_in,
   input wire logic ask_in,
   input wire logic [`PDSQ_SEL_W-1:0] ask_select_in,
   // Device announcements
   input wire logic ps_ready_in,
   input wire logic hard_reset_in,
   // Wire side
   output logic sink_present_out = 1'b0,
   output logic msg_received_out = 1'b0,
   output logic request_accept_out = 1'b0,
   output logic [`PDSQ_SEL_W-1:0] request_select_out = 3'h0,
   output logic msg_sent_out = 1'b0
);
   logic may_ask_q = 1'b1;
   // Select is only meaningful with accept, so it toggles otherwise to expose misuse.
   always @(posedge clock_in)
   begin
      sink_present_out <= attach_in;
      msg_sent_out <= ps_ready_in | hard_reset_in;
      msg_received_out <= ask_in & attach_in;
      request_accept_out <= ask_in & attach_in & may_ask_q;
      request_select_out <= (ask_in & may_ask_q) ? ask_select_in : ~request_select_out;
      if (ask_in & may_ask_q)
         may_ask_q <= 1'b0;
      else if (ps_ready_in | hard_reset_in | !attach_in)
         may_ask_q <= 1'b1;
   end
endmodule // pdsq_sink_model

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for the source power path sequencer.
// Assumes: Delays shortened by parameters; windows allow a few cycles of pipeline.
// Notes: Every expected delay is derived from the parameter values set here.
`timescale 1ns/10ps
`include "pdsq_consts.svh"
module testbench
   import pdsq_pkg::*;
;
   localparam int DEB = 30;
   localparam int ARM = 40;
   localparam int SET = 50;
   localparam int REC = 60;
   localparam int HRG = 20;
   localparam int STR = 25;
   localparam int FLT = 120;
   localparam int SHT = 85;
   localparam int TON = 100;
   localparam int SIL = 400;
   `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
   logic clock_in = 1'b0;
   logic nrst_in = 1'b0;
   logic attach = 1'b0;
   logic ask = 1'b0;
   logic [`PDSQ_SEL_W-1:0] ask_sel = 3'h0;
   logic [`PDSQ_SEL_W-1:0] sel_now = 3'h0;
   logic vbus_good_in = 1'b1;
   logic vbus_short_in = 1'b0;
   logic supply_input_in = 1'b1;
   logic fast_shutdown_in = 1'b1;
   logic fast_overvoltage_guard_in = 1'b0;
   logic overcurrent_large_in = 1'b0;
   logic thermal_trip_level_one_in = 1'b0;
   logic sink_present_in, request_accept_in, msg_received_in, msg_sent_in;
   logic [`PDSQ_SEL_W-1:0] request_select_in;
   logic srcen_n, gate, armed, guards, s1, s2, s3, adis, bleed, ind, psr, hr;
   pdsq_adv_type adv;
   int err_total = 0;
   int comparisons = 0;
   int n;
   pdsq_sequencer #(.PROT_ARM_CYC(ARM), .SETTLE_CYC(SET), .RECOVER_CYC(REC),
      .HR_GATEOFF_CYC(HRG), .DEBOUNCE_CYC(DEB), .SNK_TRANS_CYC(STR), .FAULT_RETRY_CYC(FLT),
      .SHORT_RETRY_CYC(SHT), .TURN_ON_CYC(TON), .SILENT_CYC(SIL)) i_dut (.clock_in, .nrst_in,
      .sink_present_in, .vbus_good_in, .vbus_short_in, .supply_input_in, .fast_shutdown_in,
      .fast_overvoltage_guard_in, .overcurrent_large_in, .thermal_trip_level_one_in,
      .request_accept_in, .request_select_in, .msg_received_in, .msg_sent_in,
      .source_enable_n_out(srcen_n), .nfet_gate_drive_out(gate), .protection_armed_out(armed),
      .slow_guards_enable_out(guards), .supply_select_bit1_out(s1),
      .supply_select_bit2_out(s2), .supply_select_bit3_out(s3), .active_discharge_out(adis),
      .bleed_discharge_out(bleed), .attach_indicator_out(ind), .send_ps_ready_out(psr),
      .send_hard_reset_out(hr), .cc_advert_out(adv));
   pdsq_sink_model i_sink (.clock_in, .attach_in(attach), .ask_in(ask),
      .ask_select_in(ask_sel), .ps_ready_in(psr), .hard_reset_in(hr),
      .sink_present_out(sink_present_in), .msg_received_out(msg_received_in),
      .request_accept_out(request_accept_in), .request_select_out(request_select_in),
      .msg_sent_out(msg_sent_in));
   initial
   begin
      forever #10 clock_in = ~clock_in;
   end
   task automatic tick(input int k);
      repeat (k) @(posedge clock_in);
      #1;
   endtask
   function automatic logic cond(input int s);
      case (s)
         0: return !srcen_n;
         1: return gate;
         2: return armed;
         3: return psr;
         4: return hr;
         5: return !gate;
         default: return {s3, s2, s1} !== sel_now;
      endcase
   endfunction
   // Bounded wait so that a missing event is reported instead of hanging the run.
   task automatic wait_on(input int s, input int lim, output int k);
      k = 0;
      while (cond(s) !== 1'b1 && k < lim)
      begin
         tick(1);
         k++;
      end
   endtask
   function automatic logic win(input int k, input int lo, input int hi);
      return (k >= lo) && (k <= hi);
   endfunction
   function automatic int gap_of(input int kind);
      return (kind == 0 || kind == 3) ? FLT : TON;
   endfunction
   task automatic set_fault(input int kind, input logic on);
      @(posedge clock_in);
      case (kind)
         0: fast_shutdown_in <= !on;
         1: fast_overvoltage_guard_in <= on;
         2: overcurrent_large_in <= on;
         3: supply_input_in <= !on;
         4: vbus_short_in <= on;
         default: thermal_trip_level_one_in <= on;
      endcase
      #1;
   endtask
   task automatic attach_up(input logic full);
      @(posedge clock_in);
      attach <= 1'b1;
      tick(4);
      `CHK(ind, 1'b1)
      `CHK(adv, ADV_STD)
      wait_on(0, DEB + 20, n);
      `CHK(win(n, DEB - 6, DEB + 2), 1'b1)
      if (full)
      begin
         wait_on(1, 5, n);
         `CHK(adv, ADV_3P0)
         wait_on(2, ARM + 20, n);
         `CHK(win(n, ARM - 2, ARM + 3), 1'b1)
      end
   endtask
   task automatic detach;
      @(posedge clock_in);
      attach <= 1'b0;
      tick(4);
      `CHK({gate, srcen_n, s3, s2, s1, adv}, {2'b01, 3'h0, ADV_STD})
      sel_now = 3'h0;
   endtask
   task automatic request(input logic [`PDSQ_SEL_W-1:0] pick);
      @(posedge clock_in);
      ask <= 1'b1;
      ask_sel <= pick;
      @(posedge clock_in);
      ask <= 1'b0;
      tick(1);
   endtask
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #(20 * 60000);
      err_total++;
      finish_test;
   end
   initial
   begin
      void'($urandom(61));
      repeat (8) @(posedge clock_in);
      nrst_in <= 1'b1;
      tick(2);
      attach_up(1'b1);
      // First request sets all three select bits; the rest are random changes.
      for (int i = 0; i < 5; i++)
      begin
         request((i == 0) ? 3'h7 : sel_now ^ 3'($urandom_range(1, 7)));
         wait_on(6, STR + 20, n);
         `CHK(win(n, STR - 3, STR + 3), 1'b1)
         `CHK({s3, s2, s1}, ask_sel)
         `CHK(guards, 1'b0)
         sel_now = ask_sel;
         wait_on(3, SET + 20, n);
         `CHK(win(n, SET - 2, SET + 3), 1'b1)
         tick(2);
         `CHK({guards, adv}, {1'b1, ADV_1P5})
         tick($urandom_range(0, 6));
      end
      // Detach in the middle of a transition must cancel the pending select change.
      request(sel_now ^ 3'h5);
      tick(5);
      detach();
      tick(STR + 10);
      `CHK({s3, s2, s1, psr}, 4'h0)
      attach_up(1'b1);
      wait_on(4, SIL, n);
      `CHK(win(n, SIL - ARM - 6, SIL - ARM + 4), 1'b1)
      tick(1);
      wait_on(5, HRG + 10, n);
      `CHK(win(n, HRG - 3, HRG + 2), 1'b1)
      wait_on(1, REC + DEB + 30, n);
      `CHK(win(n, REC - 1, REC + DEB + 20), 1'b1)
      detach();
      for (int k = 0; k < 4; k++)
      begin
         attach_up(1'b1);
         set_fault(k, 1'b1);
         tick(3);
         `CHK(gate, 1'b0)
         wait_on(4, gap_of(k) + 20, n);
         `CHK(win(n, gap_of(k) - 6, gap_of(k) + 3), 1'b1)
         if (k == 0 || k == 3)
         begin
            tick(1);
            wait_on(4, FLT + 20, n);
            `CHK(win(n + 1, FLT - 3, FLT + 3), 1'b1)
         end
         set_fault(k, 1'b0);
         detach();
      end
      set_fault(4, 1'b1);
      attach_up(1'b0);
      wait_on(4, SHT + TON + 20, n);
      `CHK(win(n, TON - 2, TON + 3), 1'b1)
      tick(1);
      wait_on(4, SHT + 20, n);
      `CHK({win(n + 1, SHT - 3, SHT + 3), gate}, 2'b10)
      set_fault(4, 1'b0);
      detach();
      attach_up(1'b1);
      set_fault(5, 1'b1);
      wait_on(4, 20, n);
      `CHK(hr, 1'b1)
      wait_on(5, HRG + 10, n);
      tick(2);
      `CHK({adis, bleed}, 2'b01)
      finish_test;
   end
endmodule // testbench
